// ===== src/cso_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CSO_DEFS_SVH
`define CSO_DEFS_SVH
`define CSO_ADDR_W 5
`define CSO_OFS_CTRL 5'h00
`define CSO_OFS_MOTION 5'h04
`define CSO_OFS_EVENT 5'h08
`define CSO_OFS_INHIBIT 5'h0c
`define CSO_OFS_SWITCH 5'h10
`define CSO_OFS_STATUS 5'h14
`define CSO_RST_CTRL 32'h0000_0000
`define CSO_RST_MOTION 32'h0000_0000
`define CSO_RST_INHIBIT 32'h0000_0000
`define CSO_PIN_RST 5'b00110
`define CSO_CTRL_SELFTEST_DONE 0
`define CSO_CTRL_HW_FAULT 1
`define CSO_CTRL_LOOP_OPEN 2
`define CSO_CTRL_ALARM_CAUSE 3
`define CSO_CTRL_JOG 4
`define CSO_CTRL_AUTO 5
`define CSO_CTRL_MDI 6
`define CSO_CTRL_SINGLE 7
`define CSO_CTRL_CONV 8
`define CSO_MOT_RAPID 0
`define CSO_MOT_TAP 1
`define CSO_MOT_SCREW_CUTTING_FLAG 2
`define CSO_MOT_PROBE 3
`define CSO_MOT_HOME 4
`define CSO_MOT_RIGID 5
`define CSO_MOT_CSS 6
`define CSO_MOT_RETRACED 7
`define CSO_MOT_JOG_KEY 8
`define CSO_EV_START_KEY 0
`define CSO_EV_STOP_KEY 1
`define CSO_EV_RESET_KEY 2
`define CSO_EV_MSG_CLEAR 3
`define CSO_EV_PROG_END 4
`define CSO_EV_BLOCK_DONE 5
`define CSO_EV_AT_POSITION 6
`define CSO_FEED_NIBBLE 4'h8
`define CSO_FEED_INH_BASE 8
`define CSO_FEED_LOWEST 8'h08
`define CSO_RESET_PULSE_MS 100
`define CSO_CLK_KHZ 100000
`define CSO_RESP_OKAY 2'b00
`define CSO_RESP_SLVERR 2'b10
`endif

// ===== src/cso_pkg.sv
// Types shared by the status output block
package cso_pkg;
  typedef struct packed {
    logic selftest_ok_flag;
    logic cycle_request;
    logic feed_hold_indication;
    logic reset_done_pulse;
    logic loop_open_flag;
    logic alarm_n;
    logic hw_emergency_n;
    logic jog_mode_flag;
    logic auto_mode_flag;
    logic manual_entry_flag;
    logic single_block_flag;
    logic conversational_mode_flag;
    logic in_cycle_flag;
    logic rapid_flag;
    logic tapping_flag;
    logic screw_cutting_flag;
    logic probing_flag;
    logic home_search_flag;
    logic rigid_tap_flag;
    logic constant_surface_speed_flag;
    logic reverse_path_input_complete_flag;
  } cso_status_t;
  typedef struct packed {
    logic reverse_path_input;
    logic reset_request_input;
    logic stop_input_n;
    logic feed_hold_input_n;
    logic cycle_go_input;
  } cso_plc_in_t;
  typedef enum logic [1:0] {
    CSO_RUN_IDLE,
    CSO_RUN_BUSY
  } cso_run_t;
endpackage

// ===== src/cso_status_outputs.sv
// General status outputs toward the machine logic controller
`timescale 1ns/10ps
`include "cso_defs.svh"

module cso_status_outputs
  import cso_pkg::*;
#(
  parameter bit MILL_VARIANT = 1'b1,
  parameter int RESET_PULSE_CYCLES =
    `CSO_RESET_PULSE_MS * `CSO_CLK_KHZ
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [`CSO_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [`CSO_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Panel keyboard switch, same clock domain
  input wire logic [7:0] panel_switch_code,
  // Controller inputs, asynchronous pins
  input wire cso_plc_in_t plc_in,
  // Status toward the controller
  output cso_status_t status,
  output logic [7:0] applied_position
);

  // Pins rest at their idle levels in reset, so no false edge follows
  localparam logic [4:0] SYNC_RST = `CSO_PIN_RST;
  localparam int PULSE_W = $clog2(RESET_PULSE_CYCLES + 1);

  // Pin synchronisers: three stages, change taken when 2 and 3 agree
  logic [4:0] sync1, sync2, sync3, pin_q;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync1[gi] <= SYNC_RST[gi];
          sync2[gi] <= SYNC_RST[gi];
          sync3[gi] <= SYNC_RST[gi];
          pin_q[gi] <= SYNC_RST[gi];
        end else begin
          sync1[gi] <= plc_in[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) begin
            pin_q[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate

  cso_plc_in_t pin_now, pin_prev;
  assign pin_now = cso_plc_in_t'(pin_q);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_prev <= cso_plc_in_t'(SYNC_RST);
    end else begin
      pin_prev <= pin_now;
    end
  end
  wire go_rise = pin_now.cycle_go_input & ~pin_prev.cycle_go_input;
  wire stop_fall = ~pin_now.stop_input_n & pin_prev.stop_input_n;
  wire rst_req_rise = pin_now.reset_request_input &
    ~pin_prev.reset_request_input;

  // AXI4-Lite slave: address and data taken in either order
  logic aw_held, w_held, ar_busy;
  logic [`CSO_ADDR_W-1:0] aw_addr, ar_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] ctrl, motion, inhibit;
  logic [31:0] ev_pulse;
  logic [31:0] rd_word;
  logic rd_ok;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~ar_busy;
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire wr_ctrl = do_write && aw_addr == `CSO_OFS_CTRL;
  wire wr_motion = do_write && aw_addr == `CSO_OFS_MOTION;
  wire wr_event = do_write && aw_addr == `CSO_OFS_EVENT;
  wire wr_inhibit = do_write && aw_addr == `CSO_OFS_INHIBIT;
  wire wr_known = wr_ctrl | wr_motion | wr_event | wr_inhibit;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CSO_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? `CSO_RESP_OKAY : `CSO_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Software registers; the event word is write-one-pulse, never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `CSO_RST_CTRL;
      motion <= `CSO_RST_MOTION;
      inhibit <= `CSO_RST_INHIBIT;
      ev_pulse <= '0;
    end else begin
      ev_pulse <= wr_event ? merge('0, w_data, w_strb) : '0;
      if (wr_ctrl) begin
        ctrl <= merge(ctrl, w_data, w_strb);
      end
      if (wr_motion) begin
        motion <= merge(motion, w_data, w_strb);
      end
      if (wr_inhibit) begin
        inhibit <= merge(inhibit, w_data, w_strb);
      end
    end
  end

  // Read path
  // Answer registered one edge after the address; data frozen until taken
  always_comb begin
    rd_ok = 1'b1;
    if (ar_addr == `CSO_OFS_CTRL) begin
      rd_word = ctrl;
    end else if (ar_addr == `CSO_OFS_MOTION) begin
      rd_word = motion;
    end else if (ar_addr == `CSO_OFS_EVENT) begin
      rd_word = '0;
    end else if (ar_addr == `CSO_OFS_INHIBIT) begin
      rd_word = inhibit;
    end else if (ar_addr == `CSO_OFS_SWITCH) begin
      rd_word = {16'h0000, applied_position, panel_switch_code};
    end else if (ar_addr == `CSO_OFS_STATUS) begin
      rd_word = {11'h000, status};
    end else begin
      rd_word = '0;
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_busy <= 1'b0;
      ar_addr <= '0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `CSO_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        ar_busy <= 1'b1;
        ar_addr <= s_axi_araddr;
      end else if (ar_busy && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `CSO_RESP_OKAY : `CSO_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        ar_busy <= 1'b0;
      end
    end
  end

  // Event strobes and control levels from the firmware
  wire start_key = ev_pulse[`CSO_EV_START_KEY];
  wire stop_key = ev_pulse[`CSO_EV_STOP_KEY];
  wire reset_key = ev_pulse[`CSO_EV_RESET_KEY];
  wire msg_clear = ev_pulse[`CSO_EV_MSG_CLEAR];
  wire prog_end = ev_pulse[`CSO_EV_PROG_END];
  wire block_done = ev_pulse[`CSO_EV_BLOCK_DONE];
  wire at_position = ev_pulse[`CSO_EV_AT_POSITION];
  wire jog_mode = ctrl[`CSO_CTRL_JOG];
  wire single_mode = ctrl[`CSO_CTRL_SINGLE];
  wire alarm_cause = ctrl[`CSO_CTRL_ALARM_CAUSE];

  // Applied switch position; only feed positions are substituted
  // Inhibit bits outside the feed field neither block the key nor remap the code
  function automatic logic [7:0] apply_code(input logic [7:0] sel,
                                            input logic [31:0] inh);
    logic [7:0] r;
    logic found;
    r = sel;
    found = 1'b0;
    if (sel[3:0] == `CSO_FEED_NIBBLE && sel[7:4] != 4'hf) begin
      r = `CSO_FEED_LOWEST;
      for (int i = 14; i >= 0; i--) begin
        if (!found && i <= int'(sel[7:4]) &&
            !inh[`CSO_FEED_INH_BASE + i]) begin
          r = {4'(i), `CSO_FEED_NIBBLE};
          found = 1'b1;
        end
      end
    end
    return r;
  endfunction

  wire [7:0] next_applied = apply_code(panel_switch_code, inhibit);

  // Latched stop, cleared by the next cycle start
  logic stop_latch, alarm_latch;
  cso_run_t run_state, next_run;
  logic [PULSE_W-1:0] pulse_cnt;
  wire stop_req = stop_key | stop_fall;
  wire next_stop_latch = stop_req | (stop_latch & ~go_rise);
  // Set beats clear so an alarm is never lost in the clearing cycle
  wire next_alarm = alarm_cause | (alarm_latch & ~msg_clear);

  always_comb begin
    next_run = run_state;
    case (run_state)
      CSO_RUN_IDLE: begin
        if (go_rise && !stop_req) begin
          next_run = CSO_RUN_BUSY;
        end
      end
      CSO_RUN_BUSY: begin
        if (prog_end || stop_req) begin
          next_run = CSO_RUN_IDLE;
        end else if (single_mode && block_done) begin
          next_run = CSO_RUN_IDLE;
        end else if (jog_mode && at_position) begin
          next_run = CSO_RUN_IDLE;
        end
      end
      default: next_run = CSO_RUN_IDLE;
    endcase
  end

  wire in_cycle = run_state == CSO_RUN_BUSY ||
    (jog_mode && motion[`CSO_MOT_JOG_KEY]);
  wire next_cycle_req = start_key | (status.cycle_request & ~go_rise);
  wire pulse_start = reset_key | rst_req_rise;
  wire ready = ctrl[`CSO_CTRL_SELFTEST_DONE] & ~ctrl[`CSO_CTRL_HW_FAULT];

  // Reset-done pulse; a new request restarts the full width
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_cnt <= '0;
    end else if (pulse_start) begin
      pulse_cnt <= PULSE_W'(RESET_PULSE_CYCLES);
    end else if (pulse_cnt != '0) begin
      pulse_cnt <= pulse_cnt - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_state <= CSO_RUN_IDLE;
      stop_latch <= 1'b0;
      alarm_latch <= 1'b0;
    end else begin
      run_state <= next_run;
      stop_latch <= next_stop_latch;
      alarm_latch <= next_alarm;
    end
  end

  // Registered outputs; flags low and alarm lines high at reset
  // Level flags lag their register by one edge; firmware owns the timing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= '0;
      status.alarm_n <= 1'b1;
      status.hw_emergency_n <= 1'b1;
      applied_position <= '0;
    end else begin
      status.selftest_ok_flag <= ready;
      status.cycle_request <= next_cycle_req;
      status.feed_hold_indication <= next_stop_latch |
        ~pin_now.feed_hold_input_n;
      status.reset_done_pulse <= pulse_start | (pulse_cnt > 1);
      status.loop_open_flag <= ctrl[`CSO_CTRL_LOOP_OPEN];
      status.alarm_n <= ~next_alarm;
      status.hw_emergency_n <= ~next_alarm;
      status.jog_mode_flag <= jog_mode;
      status.auto_mode_flag <= ctrl[`CSO_CTRL_AUTO];
      status.manual_entry_flag <= ctrl[`CSO_CTRL_MDI];
      status.single_block_flag <= single_mode;
      status.conversational_mode_flag <= ctrl[`CSO_CTRL_CONV];
      status.in_cycle_flag <= in_cycle;
      status.rapid_flag <= motion[`CSO_MOT_RAPID];
      status.tapping_flag <= motion[`CSO_MOT_TAP];
      status.screw_cutting_flag <= motion[`CSO_MOT_SCREW_CUTTING_FLAG];
      status.probing_flag <= motion[`CSO_MOT_PROBE];
      status.home_search_flag <= motion[`CSO_MOT_HOME];
      status.rigid_tap_flag <= MILL_VARIANT &
        motion[`CSO_MOT_RIGID];
      status.constant_surface_speed_flag <= ~MILL_VARIANT &
        motion[`CSO_MOT_CSS];
      status.reverse_path_input_complete_flag <= pin_now.reverse_path_input &
        motion[`CSO_MOT_RETRACED];
      applied_position <= next_applied;
    end
  end

endmodule // cso_status_outputs

// ===== tb/cso_checker.sv
// Concurrent checks on the status output block ports
`timescale 1ns/10ps
module cso_checker
  import cso_pkg::*;
#(
  parameter bit MILL_VARIANT = 1'b1,
  parameter int RESET_PULSE_CYCLES = 20
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus handshakes
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Switch and controller side
  input wire logic [7:0] panel_switch_code,
  input wire cso_plc_in_t plc_in,
  input wire cso_status_t status,
  input wire logic [7:0] applied_position
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  int pulse_cnt;
  // Length of the current reset-done pulse
  always_ff @(posedge aclk) begin
    if (!aresetn || !status.reset_done_pulse) pulse_cnt <= 0;
    else pulse_cnt <= pulse_cnt + 1;
  end
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence plain_code_held;
    (panel_switch_code[3:0] != 4'h8) ##1 $stable(panel_switch_code);
  endsequence
  // Reset must act even while the default disable is true
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
    status.alarm_n && status.hw_emergency_n && !status.selftest_ok_flag &&
    !status.in_cycle_flag && applied_position == 8'h00)
    else $error("outputs not at rest after reset");
  a_alarm_emerg: assert property (!status.alarm_n |-> !status.hw_emergency_n)
    else $error("hardware emergency not low during alarm");
  a_variant_css: assert property (!(MILL_VARIANT &&
    status.constant_surface_speed_flag))
    else $error("surface speed flag on milling variant");
  a_pulse_length: assert property ($fell(status.reset_done_pulse) |->
    pulse_cnt >= RESET_PULSE_CYCLES)
    else $error("reset done pulse too short");
  a_request_clear: assert property ($fell(status.cycle_request) |->
    plc_in.cycle_go_input)
    else $error("cycle request dropped without cycle go");
  a_hold_input: assert property (!plc_in.feed_hold_input_n [*8] |->
    status.feed_hold_indication)
    else $error("feed hold input not indicated");
  a_plain_applied: assert property (plain_code_held |->
    applied_position == panel_switch_code)
    else $error("applied code differs from plain selected code");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response withdrawn");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data withdrawn");
  a_read_answer: assert property (ar_taken |-> ##[1:4] s_axi_rvalid)
    else $error("read answer late");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while answer pending");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address accepted while response pending");
endmodule // cso_checker

bind cso_status_outputs cso_checker #(
  .MILL_VARIANT(MILL_VARIANT), .RESET_PULSE_CYCLES(RESET_PULSE_CYCLES)
) u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .panel_switch_code(panel_switch_code), .plc_in(plc_in), .status(status),
  .applied_position(applied_position));

// ===== tb/cso_plc_model.sv
// Behavioural controller program facing the status outputs
`timescale 1ns/10ps
module cso_plc_model
  import cso_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Device status and bench requests
  input wire cso_status_t status,
  input wire logic interlock_ok,
  input wire logic stop_n_req,
  input wire logic hold_n_req,
  input wire logic reset_req,
  input wire logic reverse_path_input_req,
  // Pins toward the device
  output cso_plc_in_t plc_in,
  output logic plc_emergency_output
);
  // Start only when our own interlocks allow it
  wire next_go = status.cycle_request && interlock_ok;
  // Low from reset, high only while ready and not in alarm
  wire next_emergency = status.selftest_ok_flag && status.alarm_n;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      plc_in <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
      plc_emergency_output <= 1'b0;
    end else begin
      plc_in <= '{reverse_path_input_req, reset_req, stop_n_req, hold_n_req, next_go};
      plc_emergency_output <= next_emergency;
    end
  end
endmodule // cso_plc_model

// ===== tb/testbench.sv
// Self-checking bench for the status output block
`timescale 1ns/10ps
`include "cso_defs.svh"
module testbench;
  import cso_pkg::*;
  localparam int PULSE = 20;
  localparam int CBIT[6] = '{2, 4, 5, 6, 7, 8};
  localparam int CIDX[6] = '{16, 13, 12, 11, 10, 9};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [7:0] sw_code = 8'h00;
  logic interlock_ok = 1'b0, stop_n_req = 1'b1, hold_n_req = 1'b1;
  logic reset_req = 1'b0, reverse_path_input_req = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, plc_emergency;
  logic [1:0] bresp, rresp, rr, br;
  logic [31:0] rdata, rd;
  logic [7:0] applied, code;
  cso_plc_in_t plc_in;
  cso_status_t status;
  int bad_count = 0, comparisons = 0, cyc = 0;
  always #5 aclk = ~aclk;
  cso_status_outputs #(.MILL_VARIANT(1'b1), .RESET_PULSE_CYCLES(PULSE)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .panel_switch_code(sw_code), .plc_in(plc_in), .status(status),
    .applied_position(applied));
  cso_plc_model u_plc (.aclk(aclk), .aresetn(aresetn), .status(status),
    .interlock_ok(interlock_ok), .stop_n_req(stop_n_req),
    .hold_n_req(hold_n_req), .reset_req(reset_req),
    .reverse_path_input_req(reverse_path_input_req), .plc_in(plc_in),
    .plc_emergency_output(plc_emergency));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  // Ready is judged mid-cycle, so the drop lands right after the edge
  task wr(input logic [4:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      br = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end while (!tb);
  endtask
  task rd_reg(input logic [4:0] a);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      rd = rdata;
      rr = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end while (!tr);
  endtask
  task ev(input int b);
    wr(`CSO_OFS_EVENT, 32'h1 << b);
    settle(3);
  endtask
  task count_pulse;
    int n;
    n = 0;
    for (int k = 0; k < 3 * PULSE; k++) begin
      @(negedge aclk);
      if (status.reset_done_pulse === 1'b1) n++;
    end
    check(n >= PULSE && n <= PULSE + 1, 1);
  endtask
  task sel(input logic [7:0] c);
    @(posedge aclk);
    sw_code <= c;
    settle(2);
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    settle(1);
    check(status, 32'h0000c000);
    check(applied, 32'h0);
    rd_reg(`CSO_OFS_CTRL);
    check(rd, `CSO_RST_CTRL);
    check(rr, `CSO_RESP_OKAY);
    rd_reg(`CSO_OFS_MOTION);
    check(rd, `CSO_RST_MOTION);
    rd_reg(`CSO_OFS_INHIBIT);
    check(rd, `CSO_RST_INHIBIT);
    rd_reg(`CSO_OFS_EVENT);
    check(rd, 32'h0);
    rd_reg(5'h18);
    check(rd, 32'h0);
    check(rr, `CSO_RESP_SLVERR);
    rd_reg(`CSO_OFS_STATUS);
    check(rd, 32'h0000c000);
    wr(`CSO_OFS_SWITCH, 32'h0);
    check(br, `CSO_RESP_SLVERR);
    $display("test reset done");
    wr(`CSO_OFS_CTRL, 32'h1);
    check(br, `CSO_RESP_OKAY);
    settle(2);
    check(status.selftest_ok_flag, 1);
    check(plc_emergency, 1);
    wr(`CSO_OFS_CTRL, 32'h3);
    settle(2);
    check(status.selftest_ok_flag, 0);
    check(plc_emergency, 0);
    for (int i = 0; i < 6; i++) begin
      wr(`CSO_OFS_CTRL, 32'h1 | (32'h1 << CBIT[i]));
      settle(2);
      check(status, 32'h10c000 | (32'h1 << CIDX[i]));
    end
    wr(`CSO_OFS_CTRL, 32'h1);
    for (int i = 0; i < 7; i++) begin
      wr(`CSO_OFS_MOTION, 32'h1 << i);
      settle(2);
      check(status, 32'h10c000 | (i < 6 ? 32'h1 << (7 - i) : 0));
    end
    wr(`CSO_OFS_MOTION, 32'h1 << `CSO_MOT_RETRACED);
    settle(2);
    check(status.reverse_path_input_complete_flag, 0);
    @(posedge aclk);
    reverse_path_input_req <= 1'b1;
    settle(10);
    check(status.reverse_path_input_complete_flag, 1);
    wr(`CSO_OFS_CTRL, 32'h11);
    wr(`CSO_OFS_MOTION, 32'h1 << `CSO_MOT_JOG_KEY);
    settle(2);
    check(status.in_cycle_flag, 1);
    wr(`CSO_OFS_MOTION, 32'h0);
    settle(2);
    check(status.in_cycle_flag, 0);
    $display("test flags done");
    wr(`CSO_OFS_CTRL, 32'h1);
    ev(`CSO_EV_START_KEY);
    check(status.cycle_request, 1);
    settle(10);
    check(status.cycle_request | status.in_cycle_flag << 1, 1);
    @(posedge aclk);
    interlock_ok <= 1'b1;
    settle(12);
    check(status.cycle_request, 0);
    check(status.in_cycle_flag, 1);
    ev(`CSO_EV_PROG_END);
    check(status.in_cycle_flag, 0);
    ev(`CSO_EV_START_KEY);
    settle(12);
    @(posedge aclk);
    stop_n_req <= 1'b0;
    settle(10);
    @(posedge aclk);
    stop_n_req <= 1'b1;
    settle(10);
    check(status.feed_hold_indication, 1);
    check(status.in_cycle_flag, 0);
    ev(`CSO_EV_START_KEY);
    settle(12);
    check(status.feed_hold_indication, 0);
    wr(`CSO_OFS_CTRL, 32'h81);
    ev(`CSO_EV_BLOCK_DONE);
    check(status.in_cycle_flag, 0);
    wr(`CSO_OFS_CTRL, 32'h11);
    ev(`CSO_EV_START_KEY);
    settle(12);
    check(status.in_cycle_flag, 1);
    ev(`CSO_EV_AT_POSITION);
    check(status.in_cycle_flag, 0);
    @(posedge aclk);
    hold_n_req <= 1'b0;
    settle(10);
    check(status.feed_hold_indication, 1);
    @(posedge aclk);
    hold_n_req <= 1'b1;
    settle(10);
    check(status.feed_hold_indication, 0);
    ev(`CSO_EV_STOP_KEY);
    check(status.feed_hold_indication, 1);
    $display("test cycle done");
    wr(`CSO_OFS_EVENT, 32'h1 << `CSO_EV_RESET_KEY);
    count_pulse();
    @(posedge aclk);
    reset_req <= 1'b1;
    count_pulse();
    wr(`CSO_OFS_CTRL, 32'h9);
    settle(2);
    check({status.alarm_n, status.hw_emergency_n, plc_emergency}, 0);
    wr(`CSO_OFS_CTRL, 32'h1);
    settle(2);
    check(status.alarm_n, 0);
    ev(`CSO_EV_MSG_CLEAR);
    check({status.alarm_n, status.hw_emergency_n, plc_emergency}, 7);
    $display("test pulse and alarm done");
    for (int i = 0; i < 23; i++) begin
      code = i < 8 ? 8'hf0 + 8'(i) : 8'h08 + 8'(16 * (i - 8));
      sel(code);
      check(applied, code);
    end
    rd_reg(`CSO_OFS_SWITCH);
    check(rd, 32'h0000e8e8);
    wr(`CSO_OFS_INHIBIT, 32'h001e0000);
    sel(8'hc8);
    check(applied, 8'h88);
    rd_reg(`CSO_OFS_SWITCH);
    check(rd, 32'h000088c8);
    wr(`CSO_OFS_INHIBIT, 32'h0000ff08);
    sel(8'h78);
    check(applied, 8'h08);
    sel(8'hf3);
    check(applied, 8'hf3);
    $display("test switch done");
    end_of_test();
  end
endmodule // testbench
